// ### hw/cmpol_consts.svh
// Offsets, field positions, reset values and encodings of the comparator output logic.
// Assumes an 8-bit register port with a 3-bit word address.
`ifndef CMPOL_CONSTS_SVH
`define CMPOL_CONSTS_SVH
`define CMPOL_ADDR_W 3
`define CMPOL_DATA_W 8
`define CMPOL_OFS_CTRL 3'h0
`define CMPOL_OFS_AUX 3'h1
`define CMPOL_OFS_DIR 3'h2
`define CMPOL_OFS_PORT 3'h3
`define CMPOL_OFS_ANA 3'h4
`define CMPOL_BIT_RES2 7
`define CMPOL_BIT_RES1 6
`define CMPOL_BIT_INV2 5
`define CMPOL_BIT_INV1 4
`define CMPOL_BIT_SWITCH 3
`define CMPOL_MODE_HI 2
`define CMPOL_MODE_LO 0
`define CMPOL_BIT_REFSEL 0
`define CMPOL_BIT_PINOUT 1
`define CMPOL_PIN_ONE 1
`define CMPOL_PIN_TWO 2
`define CMPOL_MODE_MUX4 3'h6
`define CMPOL_MODE_OFF 3'h7
`define CMPOL_CTRL_RST 8'h07
`define CMPOL_AUX_RST 8'h00
`define CMPOL_DIR_RST 8'hff
`define CMPOL_PORT_RST 8'h00
`define CMPOL_ANA_RST 8'hff
`define CMPOL_LEVEL_W 8
`endif

// ### hw/cmpol_pkg.sv
// Types shared by the comparator output logic.
// Assumes cmpol_consts.svh is on the include path.
`include "cmpol_consts.svh"
package cmpol_pkg;
    typedef enum logic [2:0]
    {
        cmpol_mode_mux4 = `CMPOL_MODE_MUX4,
        cmpol_mode_off = `CMPOL_MODE_OFF
    } cmpol_mode_t;
endpackage : cmpol_pkg

// ### hw/cmpol_sync.sv
// Two-stage synchroniser for a bus of independent asynchronous levels.
// Assumes each bit is a level; multi-bit coherence is not kept.
`timescale 1ns/1ps
module cmpol_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : cmpol_sync

// ### hw/cmpol_top.sv
// Comparator output logic: input routing, polarity, status and port pin muxing.
// Assumes analog levels arrive digitised and asynchronous; register port on clk_sys.
`timescale 1ns/1ps
`include "cmpol_consts.svh"

module cmpol_top #(
    parameter int LEVEL_W = `CMPOL_LEVEL_W
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [`CMPOL_ADDR_W-1:0] reg_addr,
    input wire logic [`CMPOL_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`CMPOL_DATA_W-1:0] reg_rdata,
    input wire logic [LEVEL_W-1:0] c1_noninverting_input,
    input wire logic [LEVEL_W-1:0] c1_inverting_input_a,
    input wire logic [LEVEL_W-1:0] c1_inverting_input_b,
    input wire logic [LEVEL_W-1:0] c2_noninverting_input,
    input wire logic [LEVEL_W-1:0] c2_inverting_input_a,
    input wire logic [LEVEL_W-1:0] c2_inverting_input_b,
    input wire logic [LEVEL_W-1:0] internal_ref_level,
    input wire logic [7:0] port_f_in,
    output logic [7:0] port_f_out,
    output logic [7:0] port_f_oe
);
    logic [`CMPOL_DATA_W-1:0] ctrl_r;
    logic [`CMPOL_DATA_W-1:0] aux_r;
    logic [7:0] port_f_direction_bits_r;
    logic [7:0] port_latch_r;
    logic [7:0] analog_mask_r;
    logic [2:0] comparator_mode_field;
    logic first_result_invert;
    logic second_result_invert;
    logic use_internal_ref;
    logic [LEVEL_W-1:0] c1_pos;
    logic [LEVEL_W-1:0] c1_neg;
    logic [LEVEL_W-1:0] c2_pos;
    logic [LEVEL_W-1:0] c2_neg;
    logic c1_raw;
    logic c2_raw;
    logic c1_out;
    logic c2_out;
    logic [1:0] res_sync;
    logic [7:0] pin_sync;
    logic [`CMPOL_DATA_W-1:0] rdata_nxt;

    function automatic logic cmpol_above(input logic [LEVEL_W-1:0] pos,
                                         input logic [LEVEL_W-1:0] neg);
        return pos > neg;
    endfunction : cmpol_above

    function automatic logic cmpol_hit(input logic [`CMPOL_ADDR_W-1:0] a,
                                       input logic [`CMPOL_ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction : cmpol_hit

    assign comparator_mode_field = ctrl_r[`CMPOL_MODE_HI:`CMPOL_MODE_LO];
    assign first_result_invert = ctrl_r[`CMPOL_BIT_INV1];
    assign second_result_invert = ctrl_r[`CMPOL_BIT_INV2];

    // Reference gate: only the four-input mux mode may pick the internal level
    assign use_internal_ref = aux_r[`CMPOL_BIT_REFSEL]
        && (comparator_mode_field == cmpol_pkg::cmpol_mode_mux4);

    always_comb
    begin
        c1_pos = use_internal_ref ? internal_ref_level : c1_noninverting_input;
        c2_pos = use_internal_ref ? internal_ref_level : c2_noninverting_input;
        c1_neg = c1_inverting_input_a;
        c2_neg = c2_inverting_input_a;
        if ((comparator_mode_field == cmpol_pkg::cmpol_mode_mux4) && ctrl_r[`CMPOL_BIT_SWITCH])
        begin
            c1_neg = c1_inverting_input_b;
            c2_neg = c2_inverting_input_b;
        end
    end

    // Equal levels resolve low; that band is uncertain in the analog part anyway
    always_comb
    begin
        c1_raw = cmpol_above(c1_pos, c1_neg);
        c2_raw = cmpol_above(c2_pos, c2_neg);
        if (comparator_mode_field == cmpol_pkg::cmpol_mode_off)
        begin
            c1_raw = 1'b0;
            c2_raw = 1'b0;
        end
    end

    // One inverted value feeds both status and pins, so their polarity cannot disagree; status lags the pins by two cycles
    assign c1_out = c1_raw ^ first_result_invert;
    assign c2_out = c2_raw ^ second_result_invert;

    cmpol_sync #(
        .WIDTH(2)
    ) u_res_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in({c2_out, c1_out}),
        .sync_out(res_sync)
    );

    cmpol_sync #(
        .WIDTH(8)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in(port_f_in),
        .sync_out(pin_sync)
    );

    // Pins: unsynchronised results bypass the latch; direction still owns the driver
    always_comb
    begin
        port_f_out = port_latch_r;
        port_f_oe = ~port_f_direction_bits_r;
        if (aux_r[`CMPOL_BIT_PINOUT])
        begin
            port_f_out[`CMPOL_PIN_ONE] = c1_out;
            port_f_out[`CMPOL_PIN_TWO] = c2_out;
        end
    end

    // Control/status: result bit positions are not stored at all
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            ctrl_r <= `CMPOL_CTRL_RST;
        else if (reg_wr && cmpol_hit(reg_addr, `CMPOL_OFS_CTRL))
            ctrl_r <= {2'h0, reg_wdata[`CMPOL_BIT_INV2:0]};
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            aux_r <= `CMPOL_AUX_RST;
        else if (reg_wr && cmpol_hit(reg_addr, `CMPOL_OFS_AUX))
            aux_r <= {6'h00, reg_wdata[1:0]};
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            port_f_direction_bits_r <= `CMPOL_DIR_RST;
        else if (reg_wr && cmpol_hit(reg_addr, `CMPOL_OFS_DIR))
            port_f_direction_bits_r <= reg_wdata;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            port_latch_r <= `CMPOL_PORT_RST;
        else if (reg_wr && cmpol_hit(reg_addr, `CMPOL_OFS_PORT))
            port_latch_r <= reg_wdata;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            analog_mask_r <= `CMPOL_ANA_RST;
        else if (reg_wr && cmpol_hit(reg_addr, `CMPOL_OFS_ANA))
            analog_mask_r <= reg_wdata;
    end

    always_comb
    begin
        rdata_nxt = '0;
        if (cmpol_hit(reg_addr, `CMPOL_OFS_CTRL))
            rdata_nxt = {res_sync, ctrl_r[`CMPOL_BIT_INV2:0]};
        else if (cmpol_hit(reg_addr, `CMPOL_OFS_AUX))
            rdata_nxt = aux_r;
        else if (cmpol_hit(reg_addr, `CMPOL_OFS_DIR))
            rdata_nxt = port_f_direction_bits_r;
        else if (cmpol_hit(reg_addr, `CMPOL_OFS_PORT))
            rdata_nxt = pin_sync & ~analog_mask_r;
        else if (cmpol_hit(reg_addr, `CMPOL_OFS_ANA))
            rdata_nxt = analog_mask_r;
    end

    // Read data stand for exactly one cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            reg_rdata <= '0;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= '0;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_rd_ctrl;
        reg_rd && cmpol_hit(reg_addr, `CMPOL_OFS_CTRL);
    endsequence

    sequence s_rd_port;
        reg_rd && cmpol_hit(reg_addr, `CMPOL_OFS_PORT);
    endsequence

    sequence s_wr_ctrl;
        reg_wr && cmpol_hit(reg_addr, `CMPOL_OFS_CTRL);
    endsequence

    chk_raw_low: assert property (
        (comparator_mode_field != cmpol_pkg::cmpol_mode_off) && (c1_pos < c1_neg)
        |-> !c1_raw && (c1_out == first_result_invert))
        else $error("comparator one high while below");

    chk_raw_high: assert property (
        (comparator_mode_field != cmpol_pkg::cmpol_mode_off) && (c2_pos > c2_neg)
        |-> c2_raw && (c2_out == !second_result_invert))
        else $error("comparator two low while above");

    chk_ref_gate: assert property (
        (comparator_mode_field != cmpol_pkg::cmpol_mode_mux4)
        |-> (c1_pos == c1_noninverting_input) && (c2_pos == c2_noninverting_input))
        else $error("internal reference used outside mux mode");

    chk_ref_both: assert property (
        (comparator_mode_field == cmpol_pkg::cmpol_mode_mux4) && aux_r[`CMPOL_BIT_REFSEL]
        |-> (c1_pos == internal_ref_level) && (c2_pos == internal_ref_level))
        else $error("internal reference missing on a comparator");

    chk_result_ro: assert property (
        s_wr_ctrl ##1 s_rd_ctrl |=> reg_rdata[`CMPOL_BIT_RES1] == $past(res_sync[0])
        && reg_rdata[`CMPOL_BIT_INV2:0] == $past(reg_wdata[`CMPOL_BIT_INV2:0], 2))
        else $error("result bits follow a write");

    chk_pin_direct: assert property (
        aux_r[`CMPOL_BIT_PINOUT] |-> port_f_out[`CMPOL_PIN_ONE] == c1_out
        && port_f_out[`CMPOL_PIN_TWO] == c2_out)
        else $error("pins not driven from results");

    chk_pin_dir: assert property (
        port_f_oe[`CMPOL_PIN_TWO:`CMPOL_PIN_ONE]
        == ~port_f_direction_bits_r[`CMPOL_PIN_TWO:`CMPOL_PIN_ONE])
        else $error("pin driver ignores direction");

    chk_invert_bits: assert property (
        (c1_out != c1_raw) == first_result_invert && (c2_out != c2_raw) == second_result_invert)
        else $error("invert bit not applied");

    chk_analog_zero: assert property (
        s_rd_port |=> (reg_rdata & $past(analog_mask_r)) == 8'h00)
        else $error("analog pin read nonzero");

    chk_same_invert: assert property (
        aux_r[`CMPOL_BIT_PINOUT] [*3] |-> res_sync[1] == $past(port_f_out[`CMPOL_PIN_TWO], 2))
        else $error("status and pin polarity differ");

    chk_sync_delay: assert property (
        s_rd_ctrl |=> reg_rdata[`CMPOL_BIT_RES2:`CMPOL_BIT_RES1] == $past({c2_out, c1_out}, 3))
        else $error("status not two stages behind result");
endmodule : cmpol_top

// ### test/cmpol_tb.sv
// Self-checking bench for the comparator output logic, with an integer reference model.
// Assumes cmpol_top with an 8-bit register port, a 250 MHz clk_sys and a synchronous nrst.
`timescale 1ns/1ps
`include "cmpol_consts.svh"
module cmpol_tb;
    logic clk_sys;
    logic nrst;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] c1p, c1a, c1b, c2p, c2a, c2b, iref, pin_in;
    logic [7:0] port_f_out;
    logic [7:0] port_f_oe;
    logic [7:0] ctl, aux, dir, lat, ana, exp_out;
    logic [1:0] e;
    logic [31:0] rnd;
    int miscompares;
    int checks_done;

    cmpol_top #(.LEVEL_W(8)) uut (
        .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .c1_noninverting_input(c1p), .c1_inverting_input_a(c1a), .c1_inverting_input_b(c1b),
        .c2_noninverting_input(c2p), .c2_inverting_input_a(c2a), .c2_inverting_input_b(c2b),
        .internal_ref_level(iref), .port_f_in(pin_in), .port_f_out(port_f_out),
        .port_f_oe(port_f_oe)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic close_out;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe, so it is sampled there
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd

    // Write then read with no gap; the low bits repeat the live setting, so results hold
    task automatic wr_rd_ctrl(input logic [7:0] d, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= `CMPOL_OFS_CTRL;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : wr_rd_ctrl

    // Reference comparator: equal levels resolve low, mode off forces both low
    function automatic logic [1:0] model_res(input int md, input int sw, input int rs,
                                             input int inv);
        int p1, p2, n1, n2;
        logic r1, r2;
        n1 = (md == 6 && sw != 0) ? c1b : c1a;
        n2 = (md == 6 && sw != 0) ? c2b : c2a;
        p1 = (md == 6 && rs != 0) ? iref : c1p;
        p2 = (md == 6 && rs != 0) ? iref : c2p;
        r1 = (md != 7) && (p1 > n1);
        r2 = (md != 7) && (p2 > n2);
        return {r2 ^ inv[1], r1 ^ inv[0]};
    endfunction : model_res

    initial
    begin
        #20000;
        miscompares++;
        close_out();
    end

    initial
    begin
        nrst = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        {c1p, c1a, c1b, c2p, c2a, c2b, iref, pin_in} = 64'h0;
        miscompares = 0;
        checks_done = 0;
        void'($urandom(19));
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(`CMPOL_OFS_CTRL, `CMPOL_CTRL_RST);
        rd(`CMPOL_OFS_AUX, `CMPOL_AUX_RST);
        rd(`CMPOL_OFS_DIR, `CMPOL_DIR_RST);
        rd(`CMPOL_OFS_ANA, `CMPOL_ANA_RST);
        rd(`CMPOL_OFS_PORT, 8'h00);
        for (int a = 5; a < 8; a++)
            rd(a[2:0], 8'h00);
        chk(port_f_oe, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 40; i++)
        begin
            // Walk every mode; index bits 3 and 4 give every switch and reference pair in 110
            ctl = 8'($urandom);
            ctl[2:0] = i[2:0];
            ctl[3] = i[3];
            aux = 8'($urandom);
            aux[0] = i[4];
            dir = 8'($urandom);
            lat = 8'($urandom);
            ana = 8'($urandom);
            rnd = $urandom;
            // Equal levels now and then, to pin down how a tie resolves
            if (i % 5 == 0)
                rnd[31:24] = rnd[23:16];
            @(posedge clk_sys);
            {c1p, c1a, c1b, c2p} <= rnd;
            {c2a, c2b, iref, pin_in} <= $urandom;
            wr(`CMPOL_OFS_CTRL, ctl);
            wr(`CMPOL_OFS_AUX, aux);
            wr(`CMPOL_OFS_DIR, dir);
            wr(`CMPOL_OFS_PORT, lat);
            wr(`CMPOL_OFS_ANA, ana);
            repeat (3) @(posedge clk_sys);
            e = model_res(ctl[2:0], ctl[3], aux[0], ctl[5:4]);
            exp_out = aux[1] ? {lat[7:3], e[1], e[0], lat[0]} : lat;
            #1 chk(port_f_out, exp_out);
            chk(port_f_oe, ~dir);
            rd(`CMPOL_OFS_CTRL, {e, ctl[5:0]});
            wr_rd_ctrl({~ctl[7:6], ctl[5:0]}, {e, ctl[5:0]});
            rd(`CMPOL_OFS_AUX, {6'h00, aux[1:0]});
            rd(`CMPOL_OFS_PORT, pin_in & ~ana);
        end
        $display("test comparator paths done");
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(`CMPOL_OFS_CTRL, `CMPOL_CTRL_RST);
        rd(`CMPOL_OFS_DIR, `CMPOL_DIR_RST);
        rd(`CMPOL_OFS_PORT, 8'h00);
        chk(port_f_oe, 8'h00);
        chk(port_f_out, `CMPOL_PORT_RST);
        $display("test mid-run reset done");
        close_out();
    end
endmodule : cmpol_tb
